// ### verilog/emb_pkg.sv
// shared constants and carrier types of the external memory bus block
`default_nettype none
package emb_pkg;

	// timing base: one oscillator period is one system clock here
	localparam int CLK_PERIOD_PS = 8000;
	localparam int OSC_PERIOD_PS = 8000;
	localparam int PROG_CYCLE_OSC = 6;   // program read cycle, oscillator periods
	localparam int RD_CYCLE_OSC = 12;    // data read cycle, oscillator periods
	localparam int HALF_CLKS = PROG_CYCLE_OSC * OSC_PERIOD_PS / CLK_PERIOD_PS;
	localparam int MCYCLE_CLKS = RD_CYCLE_OSC * OSC_PERIOD_PS / CLK_PERIOD_PS;

	// machine cycle position counter
	localparam logic [3:0] POS_LAST = 4'(MCYCLE_CLKS - 1);
	localparam logic [3:0] POS_HALF = 4'(HALF_CLKS);

	// positions inside one program read half cycle
	localparam logic [3:0] H_ALE_END = 4'h2;   // latch strobe high below this
	localparam logic [3:0] H_ADDR_END = 4'h3;  // low address on port 0 below this
	localparam logic [3:0] H_STB_FIRST = 4'h3; // program read strobe from here
	localparam logic [3:0] H_LAST = 4'(HALF_CLKS - 1);

	// positions inside one data move cycle (starts at POS_HALF)
	localparam logic [3:0] D_ALE_END = 4'h2;
	localparam logic [3:0] D_ADDR_END = 4'h3;
	localparam logic [3:0] D_STB_FIRST = 4'h4;
	localparam logic [3:0] D_STB_LAST = 4'ha;
	localparam logic [3:0] D_LAST = 4'(MCYCLE_CLKS - 1);

	// program space held on chip
	localparam logic [15:0] INT_PROG_LIMIT = 16'h3fff;

	// value forced into the port 0 latch on every external access
	localparam logic [7:0] P0_LATCH_FILL = 8'hff;

	// pin synchroniser depth and resulting sample delay
	localparam int SYNC_LAT = 3;

	// pin reset levels
	localparam logic [7:0] P0_OE_N_RST = 8'hff;
	localparam logic [7:0] P2_OUT_RST = 8'hff;

	// one external data move request from the cpu
	typedef struct packed {
		logic        write;    // 1 store, 0 read
		logic        wide_adr; // 1 data pointer form (16-bit), 0 index register form
		logic [15:0] addr;
		logic [7:0]  wdata;
	} emb_xfer_req_t;

	// byte returned from a program fetch
	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
		logic [7:0]  data;
	} emb_fetch_t;

	// byte returned from a data read
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} emb_rdata_t;

endpackage : emb_pkg
`default_nettype wire

// ### verilog/emb_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module emb_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	import emb_pkg::*;

	typedef struct packed {
		logic [W-1:0] ff1;
		logic [W-1:0] ff2;
		logic [W-1:0] ff3;
		logic [W-1:0] q;
	} emb_sync_st_t;

	emb_sync_st_t s_r;
	emb_sync_st_t s_nxt;

	// ff1 is read by ff2 only; a bit changes once stages two and three agree
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.ff1 = i_d;
		s_nxt.ff2 = s_r.ff1;
		s_nxt.ff3 = s_r.ff2;
		for (int b = 0; b < W; b++)
		begin
			if (s_r.ff2[b] == s_r.ff3[b])
				s_nxt.q[b] = s_r.ff2[b];
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign o_q = s_r.q;

endmodule : emb_sync
`default_nettype wire

// ### verilog/emb_bus.sv
// external memory bus sequencer: latch strobe, program and data strobes, ports 0 and 2
`timescale 1ns/10ps
`default_nettype none
module emb_bus (
	input  wire logic                   i_clk_sys,
	input  wire logic                   i_rst,
	// cpu side
	input  wire logic [15:0]            i_pc,
	input  wire logic                   i_xfer_valid,
	input  wire emb_pkg::emb_xfer_req_t i_xfer,
	output logic                        o_xfer_ready,
	output emb_pkg::emb_fetch_t         o_fetch,
	output emb_pkg::emb_rdata_t         o_rdata,
	output logic [3:0]                  o_bus_pos,
	// port latches (special function registers) outside this block
	input  wire logic [7:0]             i_p0_latch,
	input  wire logic [7:0]             i_p2_latch,
	output logic                        o_p0_latch_set,
	// pins
	input  wire logic                   i_external_program_select_n,
	input  wire logic [7:0]             i_p0_in,
	output logic [7:0]                  o_p0_out,
	output logic [7:0]                  o_p0_oe_n,
	output logic [7:0]                  o_p2_out,
	output logic [7:0]                  o_p2_strong,
	output logic                        o_ale,
	output logic                        o_ale_oe_n,
	output logic                        o_program_read_strobe_n,
	output logic                        o_program_read_strobe_oe_n,
	output logic                        o_rd_n,
	output logic                        o_wr_n
);
	import emb_pkg::*;

	typedef struct packed {
		logic [3:0]          pos;      // oscillator period within machine cycle
		logic                pend;     // data move accepted, waiting for its slot
		logic                dact;     // data move cycle running
		logic [3:0]          dc;       // period within data move cycle
		emb_xfer_req_t       req;
		logic                half_ext; // current program half fetches externally
		logic [15:0]         faddr;
		logic [15:0]         fcap;
		logic [SYNC_LAT-1:0] fsh;
		logic [SYNC_LAT-1:0] rsh;
		logic                pins_oe_n;
		logic                ale;
		logic                prog_n;
		logic                rd_n;
		logic                wr_n;
		logic                p0_set;
		logic [7:0]          p0_out;
		logic [7:0]          p0_oe_n;
		logic [7:0]          p2_out;
		logic [7:0]          p2_strong;
		emb_fetch_t          fetch;
		emb_rdata_t          rdata;
	} emb_state_t;

	localparam emb_state_t ST_RST = '{
		pins_oe_n: 1'b1,
		prog_n:    1'b1,
		rd_n:      1'b1,
		wr_n:      1'b1,
		p0_oe_n:   P0_OE_N_RST,
		p2_out:    P2_OUT_RST,
		default:   '0
	};

	emb_state_t s_r;
	emb_state_t s_nxt;

	logic [8:0] sync_q;
	logic       ext_sel;
	logic [3:0] pos_n;
	logic [3:0] h_n;
	logic [3:0] d_n;
	logic       fs_in;
	logic       rs_in;

	// position inside the 6-period program read half
	function automatic logic [3:0] emb_half_pos(input logic [3:0] p);
		emb_half_pos = (p >= POS_HALF) ? p - POS_HALF : p;
	endfunction : emb_half_pos

	// the select pin and port 0 input are asynchronous to the sequencer
	emb_sync #(
		.W(9)
	) u_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst    (i_rst),
		.i_d      ({i_external_program_select_n, i_p0_in}),
		.o_q      (sync_q)
	);

	assign ext_sel = ~sync_q[8];

	// a new data move is taken only when none is waiting or running
	assign o_xfer_ready = ~s_r.pend & ~s_r.dact;

	// every pin level is computed for the next period and registered, so pins never glitch
	always_comb
	begin
		s_nxt = s_r;
		pos_n = (s_r.pos == POS_LAST) ? 4'h0 : s_r.pos + 4'h1;
		s_nxt.pos = pos_n;
		s_nxt.pins_oe_n = 1'b0; // pins become outputs only after reset

		// take a request; it waits for the second half of the machine cycle
		if (i_xfer_valid && o_xfer_ready)
		begin
			s_nxt.pend = 1'b1;
			s_nxt.req = i_xfer;
		end

		// data move cycle spans the second half of one machine cycle and the first of the next
		if (s_r.dact)
		begin
			s_nxt.dc = s_r.dc + 4'h1;
			if (s_r.dc == D_LAST) // twelve periods per data cycle
			begin
				s_nxt.dact = 1'b0;
				s_nxt.dc = 4'h0;
			end
		end
		else if (s_r.pend && pos_n == POS_HALF)
		begin
			s_nxt.dact = 1'b1;
			s_nxt.dc = 4'h0;
			s_nxt.pend = 1'b0;
		end

		h_n = emb_half_pos(pos_n);
		d_n = s_nxt.dc;

		// each program half decides internal or external from the counter given now
		if (h_n == 4'h0 && !s_nxt.dact)
		begin
			s_nxt.half_ext = ext_sel || (i_pc > INT_PROG_LIMIT);
			s_nxt.faddr = i_pc; // full 16-bit fetch address
		end

		s_nxt.p0_set = 1'b0;
		s_nxt.ale = 1'b0;
		s_nxt.prog_n = 1'b1;
		s_nxt.rd_n = 1'b1;
		s_nxt.wr_n = 1'b1;

		if (s_nxt.dact)
		begin
			// one latch strobe for the data address, the next one is dropped
			s_nxt.ale = (d_n < D_ALE_END);
			s_nxt.p0_set = (d_n == 4'h0);
			if (d_n < D_ADDR_END)
			begin
				// address held one period past the latch strobe fall
				s_nxt.p0_out = s_nxt.req.addr[7:0];
				s_nxt.p0_oe_n = 8'h00;
			end
			else if (s_nxt.req.write)
			begin
				// store byte leads and trails the store strobe by one period
				s_nxt.p0_out = s_nxt.req.wdata;
				s_nxt.p0_oe_n = 8'h00;
			end
			else
			begin
				s_nxt.p0_oe_n = 8'hff;
			end
			if (d_n >= D_STB_FIRST && d_n <= D_STB_LAST)
			begin
				// only data strobes here, program strobe stays idle
				s_nxt.wr_n = ~s_nxt.req.write;
				s_nxt.rd_n = s_nxt.req.write;
			end
			if (s_nxt.req.wide_adr)
			begin
				// high address byte held on port 2 for the whole cycle
				s_nxt.p2_out = s_nxt.req.addr[15:8];
				s_nxt.p2_strong = s_nxt.req.addr[15:8];
			end
			else
			begin
				// index form: latch contents act as page select
				s_nxt.p2_out = i_p2_latch;
				s_nxt.p2_strong = 8'h00;
			end
		end
		else
		begin
			// latch strobe runs for internal fetches too, one pulse per six periods
			s_nxt.ale = (h_n < H_ALE_END);
			if (s_nxt.half_ext)
			begin
				s_nxt.p0_set = (h_n == 4'h0);
				if (h_n < H_ADDR_END)
				begin
					s_nxt.p0_out = s_nxt.faddr[7:0];
					s_nxt.p0_oe_n = 8'h00;
				end
				else
				begin
					s_nxt.p0_oe_n = 8'hff;
				end
				// three strobe periods close the six-period read
				s_nxt.prog_n = ~(h_n >= H_STB_FIRST);
				// port 2 owned by the counter high byte, latch left alone
				s_nxt.p2_out = s_nxt.faddr[15:8];
				s_nxt.p2_strong = s_nxt.faddr[15:8];
			end
			else
			begin
				// internal fetch: no program strobe, ports follow their latches
				s_nxt.p0_out = 8'h00;
				s_nxt.p0_oe_n = i_p0_latch; // open drain: drive only the zeros
				s_nxt.p2_out = i_p2_latch;
				s_nxt.p2_strong = 8'h00;
			end
		end

		// sample in the last strobe period; the synchroniser adds SYNC_LAT periods
		fs_in = ~s_r.prog_n && (emb_half_pos(s_r.pos) == H_LAST);
		rs_in = ~s_r.rd_n && (s_r.dc == D_STB_LAST);
		s_nxt.fsh = {s_r.fsh[SYNC_LAT-2:0], fs_in};
		s_nxt.rsh = {s_r.rsh[SYNC_LAT-2:0], rs_in};
		if (fs_in)
			s_nxt.fcap = s_r.faddr;

		s_nxt.fetch.valid = s_r.fsh[SYNC_LAT-1];
		if (s_r.fsh[SYNC_LAT-1])
		begin
			s_nxt.fetch.addr = s_r.fcap;
			s_nxt.fetch.data = sync_q[7:0];
		end
		s_nxt.rdata.valid = s_r.rsh[SYNC_LAT-1];
		if (s_r.rsh[SYNC_LAT-1])
			s_nxt.rdata.data = sync_q[7:0];
	end

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
			s_r <= ST_RST;
		else
			s_r <= s_nxt;
	end

	// all outputs straight from the state register
	assign o_fetch = s_r.fetch;
	assign o_rdata = s_r.rdata;
	assign o_bus_pos = s_r.pos;
	assign o_p0_latch_set = s_r.p0_set;
	assign o_p0_out = s_r.p0_out;
	assign o_p0_oe_n = s_r.p0_oe_n;
	assign o_p2_out = s_r.p2_out;
	assign o_p2_strong = s_r.p2_strong;
	assign o_ale = s_r.ale;
	assign o_ale_oe_n = s_r.pins_oe_n;
	assign o_program_read_strobe_n = s_r.prog_n;
	assign o_program_read_strobe_oe_n = s_r.pins_oe_n;
	assign o_rd_n = s_r.rd_n;
	assign o_wr_n = s_r.wr_n;

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);

	strobe_excl_a: assert property (
		!(!o_program_read_strobe_n && (!o_rd_n || !o_wr_n))
	) else $error("program strobe overlaps a data strobe");

	int_no_prog_a: assert property (
		!o_program_read_strobe_n |-> s_r.half_ext && !s_r.dact
	) else $error("program strobe on an internal fetch");

	xfer_no_prog_a: assert property (
		s_r.dact |-> o_program_read_strobe_n
	) else $error("program strobe during data move");

	rd_len_a: assert property (
		$fell(o_rd_n) |-> !o_rd_n [*7] ##1 o_rd_n ##1 o_ale
	) else $error("read strobe width or cycle end wrong");

	prog_len_a: assert property (
		$fell(o_program_read_strobe_n) |-> $past(o_ale, 3) ##0 !o_program_read_strobe_n [*3]
			##1 o_program_read_strobe_n
	) else $error("program read cycle not six periods");

	ale_gap_a: assert property (
		$fell(o_ale) && !s_r.dact |-> !o_ale [*4] ##1 o_ale
	) else $error("latch strobe not at one sixth rate");

	ale_supp_a: assert property (
		(!o_rd_n || !o_wr_n) |-> !o_ale
	) else $error("latch strobe while data strobe active");

	addr_fall_a: assert property (
		$fell(o_ale) && (s_r.half_ext || s_r.dact) |-> o_p0_oe_n == 8'h00 && $stable(o_p0_out)
	) else $error("low address not held at latch strobe fall");

	wr_data_a: assert property (
		$fell(o_wr_n) |-> $past(o_p0_oe_n) == 8'h00 && $stable(o_p0_out)
			##7 o_wr_n && o_p0_oe_n == 8'h00 && $stable(o_p0_out)
	) else $error("store byte not around the store strobe");

	latch_fill_a: assert property (
		$rose(o_ale) && (s_r.half_ext || s_r.dact) |-> o_p0_latch_set
	) else $error("port 0 latch not overwritten on external access");

	p2_wide_a: assert property (
		!o_rd_n && s_r.req.wide_adr |-> o_p2_out == s_r.req.addr[15:8]
			&& o_p2_strong == s_r.req.addr[15:8]
	) else $error("high address missing on port 2");

endmodule : emb_bus
`default_nettype wire

// ### dv/emb_mem_model.sv
// behavioural external memory behind an address latch
`timescale 1ns/10ps
`default_nettype none
module emb_mem_model (
	input  wire logic        i_clk_sys,
	input  wire logic [7:0]  i_p0_out,
	input  wire logic [7:0]  i_p0_oe_n,
	input  wire logic [7:0]  i_p2_out,
	input  wire logic        i_ale,
	input  wire logic        i_prog_n,
	input  wire logic        i_rd_n,
	input  wire logic        i_wr_n,
	output logic      [7:0]  o_p0_bus,
	output logic      [4:0]  o_rd_span
);
	logic [7:0]  dmem [logic [15:0]];
	logic [15:0] lat_r = 16'h0000;
	logic [7:0]  flt_r = 8'h5a;
	logic [7:0]  drv;
	logic [4:0]  cnt_r = 5'h00;
	logic        ale_q = 1'b0;
	logic        wr_q = 1'b1;
	logic        rd_seen = 1'b0;
	// never drives latch or program strobe pins, even in reset
	// answers only while a read strobe is low; a released bus toggles every cycle
	always @*
	begin
		drv = !i_prog_n ? (lat_r[7:0] ^ lat_r[15:8] ^ 8'h5a)
			: (dmem.exists(lat_r) ? dmem[lat_r] : ~lat_r[7:0]);
		o_p0_bus = (~i_p0_oe_n & i_p0_out)
			| (i_p0_oe_n & ((!i_rd_n || !i_prog_n) ? drv : flt_r));
	end
	// address latch closes on the falling strobe edge
	always @(negedge i_ale)
		lat_r <= {i_p2_out, o_p0_bus};
	// store byte taken in the cycle after the store strobe rises, so it must linger
	always @(posedge i_clk_sys)
	begin
		flt_r <= ~flt_r;
		ale_q <= i_ale;
		wr_q <= i_wr_n;
		if (i_wr_n && !wr_q)
			dmem[lat_r] = o_p0_bus;
		cnt_r <= (i_ale && !ale_q) ? 5'h01 : cnt_r + 5'h01;
		if (i_ale && !ale_q && rd_seen)
			o_rd_span <= cnt_r;
		if (i_ale && !ale_q)
			rd_seen <= 1'b0;
		else if (!i_rd_n)
			rd_seen <= 1'b1;
	end
endmodule : emb_mem_model
`default_nettype wire

// ### dv/tb_emb_bus.sv
// self-checking bench for the external memory bus sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_emb_bus;
	import emb_pkg::*;
	logic          i_clk_sys = 1'b0;
	logic          i_rst = 1'b1;
	logic [15:0]   i_pc = 16'h0000;
	logic          i_xfer_valid = 1'b0;
	emb_xfer_req_t i_xfer = '0;
	logic [7:0]    i_p0_latch = 8'hff;
	logic [7:0]    i_p2_latch = 8'hff;
	logic          i_sel_n = 1'b1;
	logic          o_xfer_ready, o_p0_latch_set, o_ale, o_ale_oe_n;
	logic          o_prog_n, o_prog_oe_n, o_rd_n, o_wr_n;
	emb_fetch_t    o_fetch;
	emb_rdata_t    o_rdata;
	logic [3:0]    o_bus_pos;
	logic [7:0]    o_p0_out, o_p0_oe_n, o_p2_out, o_p2_strong, p0_bus;
	logic [4:0]    rd_span;
	logic [23:0]   exp_fetch [$];
	logic [7:0]    exp_rd [$];
	logic [7:0]    shadow [logic [15:0]];
	integer        seed = 32'hef50;
	int            num_errors = 0, total_checks = 0, cycles = 0, mode = 0;
	int            n_ale = 0, n_set = 0, n_acc = 0, n0;
	logic          ale_q = 1'b0, wr_q = 1'b1, cur_dp = 1'b1;
	logic [7:0]    cur_p2 = 8'h00, d;
	logic [15:0]   pc_v, a;

	emb_bus i_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pc(i_pc),
		.i_xfer_valid(i_xfer_valid), .i_xfer(i_xfer), .o_xfer_ready(o_xfer_ready),
		.o_fetch(o_fetch), .o_rdata(o_rdata), .o_bus_pos(o_bus_pos),
		.i_p0_latch(i_p0_latch), .i_p2_latch(i_p2_latch), .o_p0_latch_set(o_p0_latch_set),
		.i_external_program_select_n(i_sel_n), .i_p0_in(p0_bus), .o_p0_out(o_p0_out),
		.o_p0_oe_n(o_p0_oe_n), .o_p2_out(o_p2_out), .o_p2_strong(o_p2_strong),
		.o_ale(o_ale), .o_ale_oe_n(o_ale_oe_n), .o_program_read_strobe_n(o_prog_n),
		.o_program_read_strobe_oe_n(o_prog_oe_n), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n));

	emb_mem_model i_mem (.i_clk_sys(i_clk_sys), .i_p0_out(o_p0_out), .i_p0_oe_n(o_p0_oe_n),
		.i_p2_out(o_p2_out), .i_ale(o_ale), .i_prog_n(o_prog_n), .i_rd_n(o_rd_n),
		.i_wr_n(o_wr_n), .o_p0_bus(p0_bus), .o_rd_span(rd_span));

	// 125 MHz clock
	initial
	begin
		forever #4 i_clk_sys = ~i_clk_sys;
	end

	task automatic check(input logic [23:0] seen, input logic [23:0] expv);
		total_checks++;
		if (seen !== expv)
		begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expv);
		end
	endtask : check

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	// wait for an idle sequencer first, so a page change never lands inside a live move
	task automatic do_xfer(input logic wr, input logic dp, input logic [15:0] ad,
			input logic [7:0] wd);
		int n;
		n = 0;
		do
		begin
			@(posedge i_clk_sys);
			n++;
		end
		while (o_xfer_ready !== 1'b1 && n < 200);
		i_xfer <= '{write: wr, wide_adr: dp, addr: dp ? ad : {~ad[15:8], ad[7:0]}, wdata: wd};
		i_p2_latch <= dp ? ~ad[15:8] : ad[15:8];
		i_xfer_valid <= 1'b1;
		@(posedge i_clk_sys);
		i_xfer_valid <= 1'b0;
		cur_dp = dp;
		cur_p2 = ad[15:8];
		if (!wr)
			exp_rd.push_back(shadow.exists(ad) ? shadow[ad] : ~ad[7:0]);
	endtask : do_xfer

	// present a fresh fetch address each half; note it when it must go off chip
	always @(posedge i_clk_sys)
		if (!i_rst && (o_bus_pos == 4'h4 || o_bus_pos == 4'ha))
		begin
			pc_v = 16'($random(seed));
			pc_v = (mode == 1) ? (pc_v | 16'h8000) : (pc_v & 16'h3fff);
			i_pc <= pc_v;
			i_p0_latch <= 8'($random(seed));
			if (mode != 0)
				exp_fetch.push_back({pc_v, pc_v[7:0] ^ pc_v[15:8] ^ 8'h5a});
		end

	// watcher: results against the oldest note, strobe overlap and pin roles
	always @(posedge i_clk_sys)
		if (!i_rst)
		begin
			ale_q <= o_ale;
			wr_q <= o_wr_n;
			if (o_ale && !ale_q)
				n_ale++;
			if (o_p0_latch_set)
				n_set++;
			if (o_fetch.valid || o_rdata.valid || (!o_wr_n && wr_q))
				n_acc++;
			if (o_fetch.valid && exp_fetch.size() == 0)
				check({o_fetch.addr, o_fetch.data}, ~{o_fetch.addr, o_fetch.data});
			else if (o_fetch.valid)
				check({o_fetch.addr, o_fetch.data}, exp_fetch.pop_front());
			if (o_rdata.valid)
				check(24'(o_rdata.data), 24'(exp_rd.pop_front()));
			if (o_rdata.valid)
				check(24'(rd_span), 24'h00000c);
			if (o_rdata.valid)
				check(24'(o_bus_pos), 24'h000008);
			if (!o_rd_n || !o_wr_n)
				check(24'({o_ale, o_prog_n, o_p2_out, o_p2_strong}),
					24'({2'b01, cur_p2, cur_dp ? cur_p2 : 8'h00}));
			if (!o_wr_n)
				check(24'(o_p0_oe_n), 24'h000000);
			if (!o_rd_n || !o_prog_n)
				check(24'(o_p0_oe_n), 24'h0000ff);
			if (!o_prog_n)
				check(24'(o_p2_strong), 24'(exp_fetch[0][23:16]));
			if (!o_prog_n)
				check(24'(o_p2_out), 24'(exp_fetch[0][23:16]));
		end

	// hang guard, far above the expected run of about 1200 cycles
	always @(posedge i_clk_sys)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			num_errors++;
			complete_run();
		end
	end

	initial
	begin
		repeat (5) @(posedge i_clk_sys);
		check(24'({o_ale_oe_n, o_prog_oe_n, o_p0_oe_n, o_p2_strong}), 24'h03ff00);
		repeat (5) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		$display("test reset done");
		// internal execution: latch strobe keeps its rate, no program strobe
		repeat (12) @(negedge i_clk_sys);
		check(24'({o_ale_oe_n, o_prog_oe_n}), 24'h000000);
		n0 = n_ale;
		repeat (120) @(negedge i_clk_sys);
		check(24'(n_ale - n0), 24'h000014);
		$display("test latch strobe rate done");
		// high addresses, then select pin with low addresses; select changes only when moot
		mode = 1;
		repeat (240) @(negedge i_clk_sys);
		@(posedge i_clk_sys);
		i_sel_n <= 1'b0;
		repeat (24) @(negedge i_clk_sys);
		mode = 2;
		repeat (240) @(negedge i_clk_sys);
		mode = 1;
		repeat (24) @(negedge i_clk_sys);
		@(posedge i_clk_sys);
		i_sel_n <= 1'b1;
		repeat (24) @(negedge i_clk_sys);
		mode = 0;
		repeat (36) @(negedge i_clk_sys);
		check(24'(exp_fetch.size()), 24'h000000);
		$display("test fetch done");
		// store by one address form, read back by the other, back to back
		for (int i = 0; i < 8; i++)
		begin
			a = 16'($random(seed));
			d = 8'($random(seed));
			do_xfer(1'b1, i[0], a, d);
			shadow[a] = d;
			do_xfer(1'b0, !i[0], a, 8'h00);
		end
		do_xfer(1'b0, 1'b1, 16'($random(seed)), 8'h00);
		repeat (48) @(negedge i_clk_sys);
		check(24'(exp_rd.size()), 24'h000000);
		check(24'(n_set), 24'(n_acc));
		$display("test data move done");
		complete_run();
	end
endmodule : tb_emb_bus
`default_nettype wire
